// File: dv/div_edge_model.sv
// Model of the reference and feedback divider outputs and the reference oscillator.
// Assumes the bench pulses go_i for one clock per phase detector cycle.
`timescale 1ns/1ps
`default_nettype none
module div_edge_model (
    input  wire logic       clk_i,
    input  wire logic       go_i,
    input  wire logic [3:0] dly_i,
    input  wire logic       alive_i,
    output logic            ref_div_o,
    output logic            fb_div_o,
    output logic            osc_o
);
    logic [4:0] n_q = 5'h1F;
    initial osc_o = 1'b0;
    // Clocks since the cycle start; a stopped oscillator stands still
    always @(posedge clk_i) begin
        n_q   <= go_i ? 5'h00 : n_q + {4'h0, n_q != 5'h1F};
        osc_o <= alive_i ? !osc_o : osc_o;
    end
    // Two-clock divider pulses, feedback trailing by dly_i clocks
    assign ref_div_o = n_q < 5'h02;
    assign fb_div_o  = n_q >= {1'b0, dly_i} && n_q < {1'b0, dly_i} + 5'h02;
endmodule
`default_nettype wire

// File: dv/lock_cfg_props.sv
// Concurrent checks on the synthesizer config decode and lock detector ports.
// Assumes a bind into frac_pll_lock_detect_cfg and a single clock domain.
`timescale 1ns/1ps
`default_nettype none
module lock_cfg_props #(
    parameter LOSS_CYCLES = 16'h0400
) (
    input wire logic       clk_i,
    input wire logic       arst_n_i,
    input wire logic       clk_en_i,
    input wire logic [2:0] modulator_order_i,
    input wire logic [1:0] dither_strength_i,
    input wire logic       charge_pump_hiz_i,
    input wire logic [2:0] lock_window_select_i,
    input wire logic [3:0] ld_mux_sel_i,
    input wire logic       reference_input_i,
    input wire logic       modulator_en_o,
    input wire logic [2:0] modulator_order_o,
    input wire logic       analog_comp_en_o,
    input wire logic       dither_en_o,
    input wire logic [1:0] dither_level_o,
    input wire logic [4:0] fb_counter_bits_o,
    input wire logic       order_illegal_o,
    input wire logic       charge_pump_out_en_o,
    input wire logic       charge_pump_hiz_o,
    input wire logic       window_reserved_o,
    input wire logic       locked_o,
    input wire logic       lock_indicator_pin_o,
    input wire logic       lock_indicator_pin_oe_n_o
);
    logic [1:0]  up_q;
    logic [15:0] quiet_q;
    logic        osc_q;
    ////////////////////////////////////////////////////////////////////////
    // Edges since reset release and idle time of the reference oscillator
    always @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            up_q    <= 2'h0;
            quiet_q <= 16'h0000;
            osc_q   <= 1'b0;
        end else begin
            up_q    <= (up_q == 2'h3) ? up_q : up_q + 2'h1;
            osc_q   <= reference_input_i;
            quiet_q <= (osc_q != reference_input_i) ? 16'h0000 : quiet_q + {15'h0000, quiet_q != 16'hFFFF};
        end
    end
    default clocking @(posedge clk_i); endclocking
    default disable iff (!arst_n_i);
    // Config inputs taken on an enabled edge once the reset copy is released
    sequence cfg_take;
        up_q == 2'h3 && clk_en_i;
    endsequence
    ////////////////////////////////////////////////////////////////////////
    ord_map_a: assert property (cfg_take ##0 modulator_order_i <= 3'h4 |=>
        modulator_order_o == $past(modulator_order_i) && modulator_en_o == ($past(modulator_order_i) != 3'h0))
        else $error("order decode wrong");
    bad_order_a: assert property (cfg_take ##0 modulator_order_i > 3'h4 |=>
        order_illegal_o && !modulator_en_o && modulator_order_o == 3'h0) else $error("illegal order not flagged");
    comp_gate_a: assert property (cfg_take |=>
        analog_comp_en_o == ($past(modulator_order_i) inside {[3'h2:3'h4]})) else $error("compensation gate wrong");
    dither_gate_a: assert property (cfg_take |=> dither_level_o == $past(dither_strength_i) &&
        dither_en_o == ($past(dither_strength_i) != 2'h3 && $past(modulator_order_i) inside {[3'h2:3'h4]}))
        else $error("dither gate wrong");
    fb_width_a: assert property (cfg_take ##0 modulator_order_i <= 3'h4 |=>
        fb_counter_bits_o == (($past(modulator_order_i) == 3'h0) ? 5'h10 : 5'h0C)) else $error("counter width wrong");
    pump_hiz_a: assert property (cfg_take |=> charge_pump_hiz_o == $past(charge_pump_hiz_i) &&
        charge_pump_out_en_o == !$past(charge_pump_hiz_i)) else $error("charge pump state wrong");
    win_resv_a: assert property (cfg_take |=>
        window_reserved_o == ($past(lock_window_select_i) > 3'h5)) else $error("reserved window flag wrong");
    pin_lock_a: assert property (cfg_take |=>
        lock_indicator_pin_o == $past(locked_o && ld_mux_sel_i == 4'h3) &&
        lock_indicator_pin_oe_n_o == $past(ld_mux_sel_i != 4'h3)) else $error("lock pin wrong");
    ref_loss_a: assert property (quiet_q > LOSS_CYCLES + 8 |-> !locked_o)
        else $error("lock held without reference");
endmodule
bind frac_pll_lock_detect_cfg lock_cfg_props #(.LOSS_CYCLES(LOSS_CYCLES)) lock_cfg_props_i (.*);
`default_nettype wire

// File: dv/tb.sv
// Self-checking bench for the synthesizer config decode and lock detector.
// Assumes div_edge_model drives the divider pins and the checker is bound in.
`timescale 1ns/1ps
`default_nettype none
module tb;
    logic       clk = 1'b0, arst_n = 1'b0, clk_en = 1'b1, hiz = 1'b0, go = 1'b0, alive = 1'b1;
    logic [2:0] order = 3'h0, win = 3'h5, ord_o;
    logic [1:0] dither_strength = 2'h3, dl_o;
    logic [3:0] mux = 4'h3, dly = 4'h0;
    logic [4:0] fbb;
    logic       ref_div, fb_div, osc, m_en, ac_en, d_en, illeg, cp_en, cp_hiz, wres, lck, pin, oe_n;
    int         err_total = 0, checks = 0, o, d;
    always #2 clk = ~clk;
    frac_pll_lock_detect_cfg #(.MEAS_W(8), .LOSS_CYCLES(16'h0010)) frac_pll_lock_detect_cfg_i (
        .clk_i(clk), .arst_n_i(arst_n), .clk_en_i(clk_en), .modulator_order_i(order), .dither_strength_i(dither_strength),
        .charge_pump_hiz_i(hiz), .lock_window_select_i(win), .ld_mux_sel_i(mux), .ref_div_out_i(ref_div),
        .fb_div_out_i(fb_div), .reference_input_i(osc), .modulator_en_o(m_en), .modulator_order_o(ord_o),
        .analog_comp_en_o(ac_en), .dither_en_o(d_en), .dither_level_o(dl_o), .fb_counter_bits_o(fbb),
        .order_illegal_o(illeg), .charge_pump_out_en_o(cp_en), .charge_pump_hiz_o(cp_hiz),
        .window_reserved_o(wres), .locked_o(lck), .lock_indicator_pin_o(pin), .lock_indicator_pin_oe_n_o(oe_n));
    div_edge_model div_edge_model_i (.clk_i(clk), .go_i(go), .dly_i(dly), .alive_i(alive),
        .ref_div_o(ref_div), .fb_div_o(fb_div), .osc_o(osc));
    ////////////////////////////////////////////////////////////////////////
    // Clock steps, comparison, divider cycles and bounded lock waits
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        checks++;
        if (seen !== exp) begin
            err_total++;
            $display("BAD %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic end_sim;
        $display("errors %0d checks %0d", err_total, checks);
        if (err_total == 0 && checks > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    task automatic pair(input logic [3:0] dl);
        dly = dl;
        go  = 1'b1;
        cyc(1);
        go  = 1'b0;
        cyc(19);
    endtask
    task automatic wait_lck(input logic v);
        int n;
        for (n = 0; n < 60 && lck !== v; n++) cyc(1);
        if (lck !== v) begin
            err_total++;
            end_sim;
        end
        chk(lck, v);
    endtask
    ////////////////////////////////////////////////////////////////////////
    // Reset values, config decode, then lock acquisition and loss
    initial begin
        cyc(11);
        chk({fbb, cp_en, oe_n, pin}, 8'h86);
        chk(lck, 0);
        cyc(1);
        arst_n = 1'b1;
        cyc(4);
        for (o = 0; o < 8; o++) for (d = 0; d < 4; d++) begin
            order = o;
            dither_strength  = d;
            cyc(2);
            chk({illeg, m_en, ord_o}, {o > 4, o inside {[1:4]}, o > 4 ? 3'h0 : o[2:0]});
            chk({ac_en, d_en, dl_o}, {o inside {[2:4]}, d != 3 && o inside {[2:4]}, d[1:0]});
            if (o < 5) chk(fbb, o == 0 ? 16 : 12);
        end
        for (o = 0; o < 8; o++) begin
            win = o;
            cyc(2);
            chk(wres, o > 5);
        end
        for (o = 0; o < 2; o++) begin
            hiz = o;
            cyc(2);
            chk({cp_hiz, cp_en}, {o[0], !o[0]});
        end
        clk_en = 1'b0;
        hiz    = 1'b0;
        cyc(2);
        chk(cp_hiz, 1);
        clk_en = 1'b1;
        order  = 3'h2;
        dither_strength   = 2'h3;
        win    = 3'h0;
        repeat (6) pair(1);
        chk(lck, 0);
        win = 3'h5;
        repeat (4) pair(1);
        chk(lck, 0);
        pair(4);
        repeat (4) pair(1);
        chk(lck, 0);
        pair(1);
        wait_lck(1);
        cyc(1);
        chk(pin, 1);
        mux = 4'h4;
        cyc(2);
        chk({pin, oe_n}, 2'b01);
        mux = 4'h3;
        pair(3);
        chk(lck, 1);
        pair(4);
        wait_lck(0);
        cyc(1);
        chk(pin, 0);
        repeat (5) pair(1);
        wait_lck(1);
        alive = 1'b0;
        wait_lck(0);
        cyc(30);
        chk({lck, pin}, 2'b00);
        end_sim;
    end
endmodule
`default_nettype wire

// File: hw/edge_window_meas.v
// Measures the time between a reference edge and a feedback edge in core cycles.
// Assumes both edge strobes are one-cycle pulses already in the clk_i domain.
`timescale 1ns/1ps
`default_nettype none

module edge_window_meas #(
    parameter W = 8
) (
    input  wire         clk_i,
    input  wire         rst_n_i,
    input  wire         en_i,
    input  wire         ref_edge_i,
    input  wire         fb_edge_i,
    output reg  [W-1:0] offset_o,
    output reg          done_o
);

    reg         open_q;
    reg [W-1:0] cnt_q;

    ////////////////////////////////////////////////////////////////////////////
    // First edge opens the gap, the next edge of either kind closes it; both at once means zero
    always @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            open_q   <= 1'b0;
            cnt_q    <= {W{1'b0}};
            offset_o <= {W{1'b0}};
            done_o   <= 1'b0;
        end else if (en_i) begin
            done_o <= 1'b0;
            if (ref_edge_i && fb_edge_i) begin
                open_q   <= 1'b0;
                offset_o <= {W{1'b0}};
                done_o   <= 1'b1;
            end else if (ref_edge_i || fb_edge_i) begin
                if (open_q) begin
                    open_q   <= 1'b0;
                    offset_o <= cnt_q;
                    done_o   <= 1'b1;
                end else begin
                    open_q <= 1'b1;
                    cnt_q  <= {{(W-1){1'b0}}, 1'b1};
                end
            end else if (open_q && cnt_q != {W{1'b1}}) begin
                cnt_q <= cnt_q + {{(W-1){1'b0}}, 1'b1}; // Saturates
            end
        end
    end

endmodule

`default_nettype wire

// File: hw/frac_pll_lock_detect_cfg.v
// Configuration decode and digital lock detector for a fractional-N synthesizer.
// Assumes divider outputs arrive as asynchronous levels; host drives config ports.
// Behaviour
// R1: Order code 0 is integer, 1 to 4 select first to fourth order.
// R2: Integer mode allows a wider feedback counter than fractional mode.
// R3: First order has no compensation or dither; codes 5 to 7 illegal.
// R4: Dither code 0 weak, 1 medium, 2 strong, 3 disabled.
// R5: Host keeps dither off in integer or first order mode.
// R6: Host should disable dither when the fractional numerator is zero.
// R7: Charge pump high-impedance bit 1 floats pump, 0 runs normally.
// R8: Lock after 5 consecutive cycles with offset below window.
// R9: Declared lock drives the lock indicator high.
// R10: Lock persists until an offset exceeds the same window.
// R11: Loss of reference input forces unlocked report.
// R12: Window codes 0 to 5 give 3.5 to 13.5 ns; 6,7 reserved.
// R13: Host uses lock detect only if minimum window at most 13.5 ns.
// R14: Host needs maximum window at least 3.5 ns.
// R15: Host keeps detector rate under 104 MHz and oscillator over 12.
// R16: Indicator mux code 3 gives push-pull lock, high only while locked.
// R17: A bad cycle before lock restarts the consecutive count.
`timescale 1ns/1ps
`default_nettype none
`include "frac_pll_map.vh"

module frac_pll_lock_detect_cfg #(
    parameter MEAS_W      = 8,
    parameter LOSS_CYCLES = 16'h0400
) (
    input  wire        clk_i,
    input  wire        arst_n_i,
    input  wire        clk_en_i,
    input  wire [2:0]  modulator_order_i,
    input  wire [1:0]  dither_strength_i,
    input  wire        charge_pump_hiz_i,
    input  wire [2:0]  lock_window_select_i,
    input  wire [3:0]  ld_mux_sel_i,
    input  wire        ref_div_out_i,
    input  wire        fb_div_out_i,
    input  wire        reference_input_i,
    output reg         modulator_en_o,
    output reg  [2:0]  modulator_order_o,
    output reg         analog_comp_en_o,
    output reg         dither_en_o,
    output reg  [1:0]  dither_level_o,
    output reg  [4:0]  fb_counter_bits_o,
    output reg         order_illegal_o,
    output reg         charge_pump_out_en_o,
    output reg         charge_pump_hiz_o,
    output reg         window_reserved_o,
    output reg         locked_o,
    output reg         lock_indicator_pin_o,
    output reg         lock_indicator_pin_oe_n_o
);

    ////////////////////////////////////////////////////////////////////////////
    // Reset release synchroniser
    reg rst_meta_q;
    reg rst_n_q;
    always @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            rst_meta_q <= 1'b0;
            rst_n_q    <= 1'b0;
        end else begin
            rst_meta_q <= 1'b1;
            rst_n_q    <= rst_meta_q;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Two-flop synchronisers then a third stage for edge detection
    reg [2:0] ref_sync_q;
    reg [2:0] fb_sync_q;
    reg [2:0] osc_sync_q;
    always @(posedge clk_i or negedge rst_n_q) begin
        if (!rst_n_q) begin
            ref_sync_q <= 3'h0;
            fb_sync_q  <= 3'h0;
            osc_sync_q <= 3'h0;
        end else if (clk_en_i) begin
            ref_sync_q <= {ref_sync_q[1:0], ref_div_out_i};
            fb_sync_q  <= {fb_sync_q[1:0], fb_div_out_i};
            osc_sync_q <= {osc_sync_q[1:0], reference_input_i};
        end
    end

    wire ref_edge = ref_sync_q[1] & ~ref_sync_q[2];
    wire fb_edge  = fb_sync_q[1] & ~fb_sync_q[2];
    wire osc_tog  = osc_sync_q[1] ^ osc_sync_q[2];

    ////////////////////////////////////////////////////////////////////////////
    // Configuration decode, registered
    always @(posedge clk_i or negedge rst_n_q) begin
        if (!rst_n_q) begin
            modulator_en_o       <= 1'b0;
            modulator_order_o    <= `ORDER_INTEGER;
            analog_comp_en_o     <= 1'b0;
            dither_en_o          <= 1'b0;
            dither_level_o       <= `DITHER_STRENGTH_WEAK;
            fb_counter_bits_o    <= `FB_BITS_INTEGER;
            order_illegal_o      <= 1'b0;
            charge_pump_out_en_o <= 1'b1;
            charge_pump_hiz_o    <= 1'b0;
            window_reserved_o    <= 1'b0;
        end else if (clk_en_i) begin
            order_illegal_o <= (modulator_order_i > `ORDER_FOURTH); // R3
            if (modulator_order_i > `ORDER_FOURTH) begin
                modulator_en_o    <= 1'b0; // R3
                modulator_order_o <= `ORDER_INTEGER;
            end else begin
                modulator_en_o    <= (modulator_order_i != `ORDER_INTEGER); // R1
                modulator_order_o <= modulator_order_i; // R1
            end
            fb_counter_bits_o <= (modulator_order_i == `ORDER_INTEGER) ?
                                 `FB_BITS_INTEGER : `FB_BITS_FRAC; // R2
            analog_comp_en_o <= (modulator_order_i > `ORDER_FIRST) &&
                                (modulator_order_i <= `ORDER_FOURTH); // R3
            dither_en_o      <= (dither_strength_i != `DITHER_STRENGTH_OFF) &&
                                (modulator_order_i > `ORDER_FIRST) &&
                                (modulator_order_i <= `ORDER_FOURTH); // R4
            dither_level_o   <= dither_strength_i; // R4
            charge_pump_hiz_o    <= charge_pump_hiz_i; // R7
            charge_pump_out_en_o <= ~charge_pump_hiz_i; // R7
            window_reserved_o    <= (lock_window_select_i > `WIN_LAST_LEGAL); // R12
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Window in core cycles: rounded down so an offset must be clearly inside, but raised to one cycle for code 0
    reg [MEAS_W-1:0] win_cycles;
    reg [31:0]       win_ps;
    reg [31:0]       win_div;
    always @* begin
        // Reserved codes fall back to the widest legal window
        win_ps = `WIN_BASE_PS + `WIN_STEP_PS * 32'h0000_0005;
        if (lock_window_select_i <= `WIN_LAST_LEGAL)
            win_ps = `WIN_BASE_PS + `WIN_STEP_PS * {29'h0000_0000, lock_window_select_i}; // R12
        win_div    = win_ps / `CLK_PERIOD_PS;
        win_cycles = win_div[MEAS_W-1:0]; // Small quotient, upper bits always zero
        if (win_cycles == {MEAS_W{1'b0}})
            win_cycles = {{(MEAS_W-1){1'b0}}, 1'b1};
    end

    ////////////////////////////////////////////////////////////////////////////
    // Edge offset measurement
    wire [MEAS_W-1:0] offset;
    wire              meas_done;
    edge_window_meas #(
        .W (MEAS_W)
    ) u_meas (
        .clk_i      (clk_i),
        .rst_n_i    (rst_n_q),
        .en_i       (clk_en_i),
        .ref_edge_i (ref_edge),
        .fb_edge_i  (fb_edge),
        .offset_o   (offset),
        .done_o     (meas_done)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Reference activity watchdog
    reg [15:0] loss_cnt_q;
    reg        ref_lost_q;
    always @(posedge clk_i or negedge rst_n_q) begin
        if (!rst_n_q) begin
            loss_cnt_q <= 16'h0000;
            ref_lost_q <= 1'b1;
        end else if (clk_en_i) begin
            if (osc_tog) begin
                loss_cnt_q <= 16'h0000;
                ref_lost_q <= 1'b0;
            end else if (loss_cnt_q >= LOSS_CYCLES - 16'h0001) begin
                ref_lost_q <= 1'b1; // R11
            end else begin
                loss_cnt_q <= loss_cnt_q + 16'h0001;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Lock state: count good cycles, drop on an offset above the window or reference loss
    reg [2:0] good_cnt_q;
    always @(posedge clk_i or negedge rst_n_q) begin
        if (!rst_n_q) begin
            good_cnt_q <= 3'h0;
            locked_o   <= 1'b0;
        end else if (clk_en_i) begin
            if (ref_lost_q) begin
                good_cnt_q <= 3'h0; // R11
                locked_o   <= 1'b0; // R11
            end else if (meas_done) begin
                if (offset < win_cycles) begin
                    if (!locked_o) begin
                        if (good_cnt_q == `LOCK_CYCLES - 3'h1) begin
                            locked_o   <= 1'b1; // R8
                            good_cnt_q <= 3'h0;
                        end else begin
                            good_cnt_q <= good_cnt_q + 3'h1; // R8
                        end
                    end
                end else if (offset > win_cycles || !locked_o) begin
                    locked_o   <= 1'b0; // R10
                    good_cnt_q <= 3'h0; // R17
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Indicator pin: push-pull lock at mux code 3, otherwise released
    always @(posedge clk_i or negedge rst_n_q) begin
        if (!rst_n_q) begin
            lock_indicator_pin_o      <= 1'b0;
            lock_indicator_pin_oe_n_o <= 1'b1;
        end else if (clk_en_i) begin
            lock_indicator_pin_o      <= (ld_mux_sel_i == `MUX_PP_LOCK) & locked_o; // R9 R16
            lock_indicator_pin_oe_n_o <= (ld_mux_sel_i != `MUX_PP_LOCK); // R16
        end
    end

endmodule

`default_nettype wire

// File: inc/frac_pll_map.vh
// Constants for the fractional synthesizer configuration and lock detector.
// Assumes a 250 MHz core clock; times are in picoseconds.
`ifndef FRAC_PLL_MAP_VH
`define FRAC_PLL_MAP_VH

// Modulator order codes
`define ORDER_INTEGER      3'h0
`define ORDER_FIRST        3'h1
`define ORDER_FOURTH       3'h4
// Dither codes
`define DITHER_STRENGTH_WEAK          2'h0
`define DITHER_STRENGTH_MEDIUM        2'h1
`define DITHER_STRENGTH_STRONG        2'h2
`define DITHER_STRENGTH_OFF           2'h3
// Feedback counter widths per mode
`define FB_BITS_INTEGER    5'h10
`define FB_BITS_FRAC       5'h0C
// Lock window field
`define WIN_DEFAULT        3'h0
`define WIN_LAST_LEGAL     3'h5
`define WIN_BASE_PS        3500
`define WIN_STEP_PS        2000
`define CLK_PERIOD_PS      4000
// Consecutive good cycles before lock
`define LOCK_CYCLES        3'h5
// Indicator mux code for push-pull digital lock
`define MUX_PP_LOCK        4'h3
// Reference loss timeout in core cycles
`define REF_LOSS_CYCLES    16'h0400

`endif
